// ===== src/cbs_pkg.sv
// Shared constants and types for the bus cycle sequencer
package cbs_pkg;

    // Machine cycle kinds presented on the command port
    localparam logic [2:0] CBS_KIND_FETCH       = 3'h0;  // Opcode fetch
    localparam logic [2:0] CBS_KIND_MEM_READ    = 3'h1;  // Memory read
    localparam logic [2:0] CBS_KIND_MEM_WRITE   = 3'h2;  // Memory write
    localparam logic [2:0] CBS_KIND_STACK_READ  = 3'h3;  // Stack read
    localparam logic [2:0] CBS_KIND_STACK_WRITE = 3'h4;  // Stack write
    localparam logic [2:0] CBS_KIND_INPUT       = 3'h5;  // I/O input
    localparam logic [2:0] CBS_KIND_OUTPUT      = 3'h6;  // I/O output
    localparam logic [2:0] CBS_KIND_IRQ_ACK     = 3'h7;  // Interrupt acknowledge (internal)

    // Status byte bit positions
    localparam int CBS_ST_IRQ_ACK   = 0;  // Interrupt acknowledge
    localparam int CBS_ST_WRITE_N   = 1;  // Low for write or output
    localparam int CBS_ST_STACK     = 2;  // Stack address on bus
    localparam int CBS_ST_HALT_ACK  = 3;  // Halt acknowledge
    localparam int CBS_ST_OUT       = 4;  // Output device address
    localparam int CBS_ST_FETCH     = 5;  // Opcode fetch
    localparam int CBS_ST_INP       = 6;  // Input device address
    localparam int CBS_ST_MEM_READ  = 7;  // Memory read data

    // Restart opcode pattern and vector layout
    localparam logic [7:0] CBS_RST_MASK   = 8'hc7;  // Fixed bits of restart opcode
    localparam logic [7:0] CBS_RST_MATCH  = 8'hc7;  // Value of the fixed bits
    localparam int         CBS_RST_FIELD_LSB = 3;   // Low bit of the target field
    localparam int         CBS_RST_FIELD_W   = 3;   // Width of the target field

    // Internal state count limits
    localparam logic [1:0] CBS_EXT_NONE = 2'h0;  // No internal states
    localparam logic [1:0] CBS_EXT_ONE  = 2'h1;  // State four only

    // Reset values
    localparam logic [15:0] CBS_ADDR_RST = 16'h0000;  // Address bus after reset
    localparam logic [7:0]  CBS_DATA_RST = 8'h00;     // Data bus after reset

    // Sequencer states, one-hot
    typedef enum logic [6:0] {
        CBS_IDLE  = 7'b000_0001,
        CBS_ONE   = 7'b000_0010,
        CBS_TWO   = 7'b000_0100,
        CBS_WAIT  = 7'b000_1000,
        CBS_THREE = 7'b001_0000,
        CBS_FOUR  = 7'b010_0000,
        CBS_FIVE  = 7'b100_0000
    } cbs_state_t;

endpackage

// ===== src/cbs_sequencer.sv
// Machine-cycle sequencer and external bus interface
//
// Behaviour
// (R01) State three: fetch takes instruction, reads take data
// (R02) Input cycle releases data lines in state two
// (R03) Data-in strobe only in read-type cycles
// (R04) Data-in strobe spans state two to three
// (R05) Output byte driven from state two onward
// (R06) Output cycle waits for ready, data held
// (R07) Write strobe only in write-type cycles
// (R08) Write strobe low after two, high after three
// (R09) Three basic states plus any wait states
// (R10) Cycle ends at three, four or five
// (R11) State one drives address and status byte
// (R12) State two samples ready, hold and halt
// (R13) Ready low or halt enters wait state
// (R14) States four, five internal only, skippable
// (R15) Peripheral raises interrupt request asynchronously
// (R16) Synchronised request latched in instruction's last state
// (R17) Acknowledge cycle status has fetch and ack
// (R18) Acknowledge cycle address is unincremented counter
// (R19) External logic jams instruction during state three
// (R20) Restart vector is eight times field
// (R21) Wait output raised on entering wait state
// (R22) Cycle sync high during state one
// (R23) Interrupt latch cleared at acknowledge start
`timescale 1ns/100ps
`default_nettype none

module cbs_sequencer
    import cbs_pkg::*;
(
    input  wire logic        mclk_i,             // System clock, 125 MHz
    input  wire logic        nrst_i,             // Synchronous reset, active low
    input  wire logic        cmd_valid_i,        // Next machine cycle offered
    input  wire logic [2:0]  cmd_kind_i,         // Kind of the offered cycle
    input  wire logic [15:0] cmd_addr_i,         // Address or device number
    input  wire logic [7:0]  cmd_wdata_i,        // Byte to write or output
    input  wire logic [1:0]  cmd_int_states_i,   // Internal states after three (0..2)
    input  wire logic        cmd_last_i,         // Cycle is the instruction's last
    input  wire logic        halt_i,             // Halt instruction executed
    input  wire logic        irq_enable_set_i,   // Enable interrupts
    input  wire logic        irq_enable_clr_i,   // Disable interrupts
    input  wire logic        ready_i,            // Ready pin, asynchronous
    input  wire logic        hold_i,             // Hold pin, asynchronous
    input  wire logic        irq_i,              // Interrupt request pin, asynchronous
    input  wire logic [7:0]  data_i,             // Data bus input
    output logic             cmd_ready_o,        // Offered cycle is taken this edge
    output logic             cycle_done_o,       // Pulse: state three finished
    output logic [7:0]       rdata_o,            // Byte taken in state three
    output logic             fetch_done_o,       // Pulse: rdata_o is an instruction
    output logic             ack_cycle_o,        // Current cycle is an acknowledge
    output logic             rst_valid_o,        // Pulse: restart jammed
    output logic [15:0]      rst_vector_o,       // Restart target address
    output logic             hold_sampled_o,     // Hold level seen in state two
    output logic [15:0]      addr_o,             // Address bus
    output logic [7:0]       data_o,             // Data bus output
    output logic             data_oe_n_o,        // Data bus enable, low drives
    output logic             sync_o,             // Cycle sync
    output logic             data_in_strobe_o,   // Data-in strobe
    output logic             wr_n_o,             // Write strobe, active low
    output logic             wait_state_o,       // Wait acknowledge
    output logic             irq_enable_out_o    // Interrupt enable flag
);

    // State of the sequencer except the captured write byte
    typedef struct packed {
        cbs_state_t  state;      // Current machine state
        logic [2:0]  kind;       // Kind of running cycle
        logic [1:0]  ext;        // Internal states requested
        logic        last;       // Running cycle ends the instruction
        logic        ready_s1;   // Ready synchroniser stage one
        logic        ready_s2;   // Ready synchroniser stage two
        logic        hold_s1;    // Hold synchroniser stage one
        logic        hold_s2;    // Hold synchroniser stage two
        logic        irq_s1;     // Request synchroniser stage one
        logic        irq_s2;     // Request synchroniser stage two
        logic        irq_latch;  // Accepted interrupt pending
        logic        irq_enable_out;       // Interrupt enable
        logic        cmd_ready;  // Command port ready
        logic        done;       // State three finished
        logic [7:0]  rdata;      // Byte taken in state three
        logic        fetch_done; // Instruction byte taken
        logic        ack;        // Acknowledge cycle running
        logic        rst_valid;  // Restart decoded
        logic [15:0] rst_vector; // Restart target
        logic        hold_seen;  // Hold sampled in state two
        logic [15:0] addr;       // Address bus
        logic [7:0]  dout;       // Data bus output
        logic        doe_n;      // Data bus enable, low drives
        logic        sync;       // Cycle sync
        logic        data_in_strobe;       // Data-in strobe
        logic        wr_n;       // Write strobe
        logic        wait_st;    // Wait acknowledge
    } cbs_regs_t;

    cbs_regs_t r;       // Registered state
    cbs_regs_t next_r;  // Next state

    // Read-type kinds that use the data-in strobe
    function automatic logic is_read(input logic [2:0] k);
        is_read = (k == CBS_KIND_FETCH) || (k == CBS_KIND_MEM_READ) ||
                  (k == CBS_KIND_STACK_READ) || (k == CBS_KIND_IRQ_ACK);
    endfunction

    // Write-type kinds that use the write strobe
    function automatic logic is_write(input logic [2:0] k);
        is_write = (k == CBS_KIND_MEM_WRITE) || (k == CBS_KIND_STACK_WRITE) ||
                   (k == CBS_KIND_OUTPUT);
    endfunction

    // True in the state after which the cycle ends
    function automatic logic is_final(input cbs_state_t s, input logic [1:0] e);
        is_final = ((s == CBS_THREE) && (e == CBS_EXT_NONE)) ||
                   ((s == CBS_FOUR) && (e == CBS_EXT_ONE)) ||
                   (s == CBS_FIVE);
    endfunction

    // Status byte for a cycle kind
    function automatic logic [7:0] status_byte(input logic [2:0] k);
        logic [7:0] s;
        s = CBS_DATA_RST;
        s[CBS_ST_WRITE_N] = !is_write(k);
        s[CBS_ST_FETCH]   = (k == CBS_KIND_FETCH) || (k == CBS_KIND_IRQ_ACK);  // [R17]
        s[CBS_ST_IRQ_ACK] = (k == CBS_KIND_IRQ_ACK);                           // [R17]
        s[CBS_ST_STACK]   = (k == CBS_KIND_STACK_READ) || (k == CBS_KIND_STACK_WRITE);
        s[CBS_ST_OUT]     = (k == CBS_KIND_OUTPUT);
        s[CBS_ST_INP]     = (k == CBS_KIND_INPUT);
        s[CBS_ST_MEM_READ] = (k == CBS_KIND_FETCH) || (k == CBS_KIND_MEM_READ) ||
                             (k == CBS_KIND_STACK_READ);
        status_byte = s;
    endfunction

    // Write byte kept from the command until state two puts it out
    logic [7:0] cmd_wdata_q;  // Captured write byte

    // Next-state logic
    always_comb begin
        logic       start;   // A new cycle begins at this edge
        logic       leave;   // Current cycle ends at this edge
        logic [2:0] kind_n;  // Kind of the cycle being started
        start  = 1'b0;
        leave  = 1'b0;
        kind_n = cmd_kind_i;
        next_r = r;

        // Pin synchronisers, second stage read only by the logic below
        next_r.ready_s1 = ready_i;
        next_r.ready_s2 = r.ready_s1;
        next_r.hold_s1  = hold_i;
        next_r.hold_s2  = r.hold_s1;
        next_r.irq_s1   = irq_i;  // [R15]
        next_r.irq_s2   = r.irq_s1;  // [R16]

        // One-cycle pulses default low
        next_r.done       = 1'b0;
        next_r.fetch_done = 1'b0;
        next_r.rst_valid  = 1'b0;
        next_r.sync       = 1'b0;
        next_r.wait_st    = 1'b0;

        // Interrupt enable control, set wins over clear
        if (irq_enable_clr_i) begin
            next_r.irq_enable_out = 1'b0;
        end
        if (irq_enable_set_i) begin
            next_r.irq_enable_out = 1'b1;
        end

        unique case (r.state)
            // Nothing offered yet
            CBS_IDLE: begin
                start = cmd_valid_i;
            end

            // Address and status out, always followed by state two
            CBS_ONE: begin
                next_r.state = CBS_TWO;  // [R09]
                if (is_read(r.kind)) begin
                    next_r.doe_n = 1'b1;  // [R02]
                    next_r.data_in_strobe  = 1'b1;  // [R03] [R04]
                end else if (is_write(r.kind)) begin
                    next_r.dout  = cmd_wdata_q;  // [R05]
                    next_r.doe_n = 1'b0;  // [R05]
                end else begin
                    next_r.doe_n = 1'b1;  // [R02]
                end
            end

            // Sample ready, hold and halt; wait or proceed
            CBS_TWO: begin
                next_r.hold_seen = r.hold_s2;  // [R12]
                if (!r.ready_s2 || halt_i) begin
                    next_r.state   = CBS_WAIT;  // [R13] [R06]
                    next_r.wait_st = 1'b1;  // [R21]
                end else begin
                    next_r.state = CBS_THREE;  // [R09]
                end
                if (is_write(r.kind)) begin
                    next_r.wr_n = 1'b0;  // [R07] [R08]
                end
            end

            // Idle until ready returns and halt is gone
            CBS_WAIT: begin
                if (r.ready_s2 && !halt_i) begin
                    next_r.state = CBS_THREE;  // [R06] [R13]
                end else begin
                    next_r.wait_st = 1'b1;  // [R21]
                end
            end

            // Data transfer, byte taken at the end of the state
            CBS_THREE: begin
                next_r.done = 1'b1;
                next_r.data_in_strobe = 1'b0;  // [R04]
                next_r.wr_n = 1'b1;  // [R08]
                // Input cycles take the device's byte as well
                if (is_read(r.kind) || (r.kind == CBS_KIND_INPUT)) begin  // [R02]
                    next_r.rdata      = data_i;  // [R01] [R19]
                    next_r.fetch_done = (r.kind == CBS_KIND_FETCH) ||
                                        (r.kind == CBS_KIND_IRQ_ACK);  // [R01]
                end

                if ((r.kind == CBS_KIND_IRQ_ACK) &&
                    ((data_i & CBS_RST_MASK) == CBS_RST_MATCH)) begin
                    next_r.rst_valid  = 1'b1;  // [R20]
                    next_r.rst_vector = rst_target(data_i);  // [R20]
                end

                if (r.ext == CBS_EXT_NONE) begin
                    leave = 1'b1;  // [R10]
                end else begin
                    next_r.state = CBS_FOUR;  // [R14]
                end
            end

            // Internal state, bus left untouched
            CBS_FOUR: begin
                if (r.ext == CBS_EXT_ONE) begin
                    leave = 1'b1;  // [R10] [R14]
                end else begin
                    next_r.state = CBS_FIVE;  // [R14]
                end
            end

            // Last internal state
            CBS_FIVE: begin
                leave = 1'b1;  // [R10]
            end

            // Illegal code: recover to idle
            default: begin
                next_r.state = CBS_IDLE;
            end
        endcase

        // Latch an enabled request in the instruction's last state
        if (leave && r.last && r.irq_s2 && r.irq_enable_out) begin
            next_r.irq_latch = 1'b1;  // [R16]
        end

        // Straight into state one of the next cycle when one is offered
        if (leave) begin
            start = cmd_valid_i;  // [R10]

            if (!cmd_valid_i) begin
                next_r.state = CBS_IDLE;
            end
        end

        // Launch a cycle; a pending interrupt replaces the fetch
        if (start) begin
            if (r.irq_latch && (cmd_kind_i == CBS_KIND_FETCH)) begin
                kind_n           = CBS_KIND_IRQ_ACK;  // [R17]
                next_r.irq_latch = 1'b0;  // [R23]
                next_r.irq_enable_out      = irq_enable_set_i;
            end

            next_r.state = CBS_ONE;
            next_r.kind  = kind_n;
            next_r.ext   = (kind_n == CBS_KIND_IRQ_ACK) ? CBS_EXT_NONE : cmd_int_states_i;
            next_r.last  = cmd_last_i;
            next_r.ack   = (kind_n == CBS_KIND_IRQ_ACK);
            next_r.addr  = cmd_addr_i;  // [R11] [R18]
            next_r.dout  = status_byte(kind_n);  // [R11]
            next_r.doe_n = 1'b0;  // [R11]
            next_r.sync  = 1'b1;  // [R22]
            next_r.data_in_strobe  = 1'b0;
            next_r.wr_n  = 1'b1;
        end

        // Ready for a command whenever the next state ends a cycle
        next_r.cmd_ready = (next_r.state == CBS_IDLE) ||
                           is_final(next_r.state, next_r.ext);
    end

    // Capture the write byte when a cycle is launched
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            cmd_wdata_q <= CBS_DATA_RST;
        end else if (cmd_valid_i && r.cmd_ready) begin
            cmd_wdata_q <= cmd_wdata_i;  // [R05]
        end
    end

    // Restart target: the three-bit field times eight
    function automatic logic [15:0] rst_target(input logic [7:0] op);
        rst_target = {10'h000, op[CBS_RST_FIELD_LSB +: CBS_RST_FIELD_W], 3'h0};  // [R20]
    endfunction

    // State register
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            r            <= '0;
            r.state      <= CBS_IDLE;
            r.kind       <= CBS_KIND_FETCH;
            r.cmd_ready  <= 1'b1;
            r.addr       <= CBS_ADDR_RST;
            r.dout       <= CBS_DATA_RST;
            r.doe_n      <= 1'b1;
            r.wr_n       <= 1'b1;
            r.rdata      <= CBS_DATA_RST;
            r.rst_vector <= CBS_ADDR_RST;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register
    assign cmd_ready_o      = r.cmd_ready;
    assign cycle_done_o     = r.done;
    assign rdata_o          = r.rdata;
    assign fetch_done_o     = r.fetch_done;
    assign ack_cycle_o      = r.ack;
    assign rst_valid_o      = r.rst_valid;
    assign rst_vector_o     = r.rst_vector;
    assign hold_sampled_o   = r.hold_seen;
    assign addr_o           = r.addr;
    assign data_o           = r.dout;
    assign data_oe_n_o      = r.doe_n;
    assign sync_o           = r.sync;
    assign data_in_strobe_o = r.data_in_strobe;
    assign wr_n_o           = r.wr_n;
    assign wait_state_o     = r.wait_st;
    assign irq_enable_out_o = r.irq_enable_out;

endmodule

`default_nettype wire

// ===== verification/cbs_bus_model.sv
// Memory, I/O and interrupting device model on the far side of the bus
`timescale 1ns/100ps
`default_nettype none

module cbs_bus_model
    import cbs_pkg::*;
(
    input  wire logic        mclk_i,      // System clock
    input  wire logic [15:0] addr_i,      // Address bus
    input  wire logic [7:0]  bus_i,       // Resolved data bus
    input  wire logic        bus_oe_n_i,  // Sequencer drives when low
    input  wire logic        sync_i,      // Cycle sync
    input  wire logic        strobe_i,    // Data-in strobe
    input  wire logic        wr_n_i,      // Write strobe
    input  wire logic        ack_i,       // Acknowledge cycle running
    input  wire logic        stall_i,     // Hold ready low for a while
    input  wire logic        irq_req_i,   // Bench asks for an interrupt
    input  wire logic [7:0]  jam_i,       // Restart byte to jam
    output logic             ready_o,     // Ready pin
    output wire logic        irq_o,       // Interrupt pin
    output logic [7:0]       drive_o,     // Byte put on the bus
    output logic [7:0]       wr_byte_o    // Last byte written
);
    logic [3:0] cnt  = 4'h0;   // Cycles since state one
    logic       inp  = 1'b0;   // Current cycle is an input
    logic [7:0] last = 8'h00;  // Previous model drive value, put out inverted when idle

    // Request reaches the pin off the clock grid
    assign #3 irq_o = irq_req_i;
    // Slow device keeps ready low for three cycles after state one
    assign ready_o = !(stall_i && cnt < 4'h3);
    // Jam the restart byte alone in acknowledge, else memory data; idle bus toggles
    assign drive_o = (strobe_i || (inp && bus_oe_n_i && !sync_i))
        ? (ack_i ? jam_i : addr_i[7:0] ^ 8'h5a) : ~last;

    // Track the cycle and capture written bytes
    always @(posedge mclk_i) begin
        cnt <= (sync_i || !stall_i) ? 4'h0 : cnt + {3'h0, cnt != 4'hf};
        if (sync_i) begin
            inp <= bus_i[CBS_ST_INP];
        end
        if (!wr_n_i) begin
            wr_byte_o <= bus_i;
        end
        last <= drive_o;
    end
endmodule

`default_nettype wire

// ===== verification/cbs_sequencer_props.sv
// Concurrent checks on the bus cycle sequencer ports
`timescale 1ns/100ps
`default_nettype none

module cbs_sequencer_props
    import cbs_pkg::*;
(
    input wire logic        mclk_i,
    input wire logic        nrst_i,
    input wire logic        cmd_valid_i,
    input wire logic        cmd_ready_o,
    input wire logic        cycle_done_o,
    input wire logic        ack_cycle_o,
    input wire logic [15:0] addr_o,
    input wire logic [7:0]  data_o,
    input wire logic        data_oe_n_o,
    input wire logic        sync_o,
    input wire logic        data_in_strobe_o,
    input wire logic        wr_n_o,
    input wire logic        wait_state_o
);
    // One clock domain, reset aborts every check
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    a_take_sync: assert property (cmd_valid_i && cmd_ready_o |=> sync_o)
        else $error("no state one after a taken command");
    a_sync_pulse: assert property (sync_o |=> !sync_o)
        else $error("cycle sync longer than one state");
    a_rd_strobe: assert property (sync_o && (data_o[CBS_ST_MEM_READ] || data_o[CBS_ST_IRQ_ACK])
        |=> data_in_strobe_o)
        else $error("data-in strobe missing in state two");
    a_wr_no_strobe: assert property (sync_o && !data_o[CBS_ST_WRITE_N]
        |=> !data_in_strobe_o [*3])
        else $error("data-in strobe in a write cycle");
    a_wr_strobe: assert property (sync_o && !data_o[CBS_ST_WRITE_N]
        |=> wr_n_o ##1 !wr_n_o)
        else $error("write strobe not low after state two");
    a_rd_no_wr: assert property (sync_o && data_o[CBS_ST_WRITE_N] |=> wr_n_o [*3])
        else $error("write strobe in a read cycle");
    a_done_time: assert property (sync_o ##2 !wait_state_o |=> cycle_done_o)
        else $error("cycle not done after state three");
    a_wait_hold: assert property (wait_state_o |-> $stable(addr_o) && !cmd_ready_o
        && (data_oe_n_o || $stable(data_o)))
        else $error("bus changed during a wait state");
    a_ack_start: assert property ($rose(ack_cycle_o)
        |-> sync_o && data_o[CBS_ST_IRQ_ACK] && data_o[CBS_ST_FETCH])
        else $error("acknowledge status wrong");
    a_in_release: assert property (sync_o && data_o[CBS_ST_INP] |=> data_oe_n_o)
        else $error("data lines not released in input cycle");
    a_out_drive: assert property (sync_o && !data_o[CBS_ST_WRITE_N] |=> !data_oe_n_o)
        else $error("write data not driven in state two");
endmodule

bind cbs_sequencer cbs_sequencer_props cbs_sequencer_props_i (.*);

`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the bus cycle sequencer
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("Error %s expected %0h seen %0h", nm, e, g); \
    end \
end

module tb
    import cbs_pkg::*;
;
    logic        mclk_i = 1'b0, nrst_i = 1'b0, cmd_valid_i = 1'b0, cmd_last_i = 1'b0;
    logic [2:0]  cmd_kind_i = 3'h0;
    logic [15:0] cmd_addr_i = 16'h0000;
    logic [7:0]  cmd_wdata_i = 8'h00, jam = 8'h00;
    logic [1:0]  cmd_int_states_i = 2'h0;
    logic        hold_i = 1'b0, irq_enable_set_i = 1'b0, irq_enable_clr_i = 1'b0;
    logic        stall = 1'b0, irq_req = 1'b0;
    wire logic   ready_i, irq_i, cmd_ready_o, cycle_done_o, fetch_done_o, ack_cycle_o;
    wire logic   rst_valid_o, hold_sampled_o, sync_o, data_oe_n_o, data_in_strobe_o;
    wire logic   wr_n_o, wait_state_o, irq_enable_out_o;
    wire logic [7:0]  rdata_o, data_o, mdl_data, wr_byte;
    wire logic [15:0] rst_vector_o, addr_o;
    // Resolved data bus: sequencer wins while it drives
    wire logic [7:0]  bus_w = !data_oe_n_o ? data_o : mdl_data;
    // Observations of one cycle
    logic [7:0]  st, rd;
    logic [15:0] ad, rv;
    logic        oe2, fd, ack, rvs, wbad;
    int          dlen, wlen, wt, len, n_errors = 0, cmp_count = 0, cyc = 0;
    logic [7:0]  stab [7] = '{8'ha2, 8'h82, 8'h00, 8'h86, 8'h04, 8'h42, 8'h10};

    cbs_sequencer cbs_sequencer_i (.*, .halt_i(1'b0), .data_i(bus_w));

    cbs_bus_model cbs_bus_model_i (
        .mclk_i(mclk_i), .addr_i(addr_o), .bus_i(bus_w), .bus_oe_n_i(data_oe_n_o),
        .sync_i(sync_o), .strobe_i(data_in_strobe_o), .wr_n_i(wr_n_o), .ack_i(ack_cycle_o),
        .stall_i(stall), .irq_req_i(irq_req), .jam_i(jam), .ready_o(ready_i), .irq_o(irq_i),
        .drive_o(mdl_data), .wr_byte_o(wr_byte));

    // Report counts and end the run
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Offer one cycle and watch it from state one until the next may start
    task automatic run(input logic [2:0] k, input logic [15:0] a, input logic [1:0] ni,
                       input logic lst);
        int   i;
        logic done;
        @(posedge mclk_i);
        {cmd_kind_i, cmd_addr_i, cmd_wdata_i} <= {k, a, ~a[7:0]};
        {cmd_int_states_i, cmd_last_i, cmd_valid_i} <= {ni, lst, 1'b1};
        @(negedge mclk_i);
        while (cmd_ready_o !== 1'b1) @(negedge mclk_i);
        @(posedge mclk_i);
        cmd_valid_i <= 1'b0;
        {dlen, wlen, wt, len} = '0;
        {ack, rvs, wbad, done} = '0;
        @(negedge mclk_i);
        st = data_o;
        ad = addr_o;
        for (i = 0; i < 40 && !(cmd_ready_o && done); i++) begin
            dlen += data_in_strobe_o;
            wlen += !wr_n_o;
            wt += wait_state_o;
            len += !cmd_ready_o;
            ack |= ack_cycle_o;
            wbad |= !wr_n_o && (data_o !== ~a[7:0] || data_oe_n_o);
            if (i == 1) oe2 = data_oe_n_o;
            if (rst_valid_o) rv = rst_vector_o;
            rvs |= rst_valid_o;
            if (cycle_done_o) {rd, fd} = {rdata_o, fetch_done_o};
            done |= cycle_done_o;
            @(negedge mclk_i);
        end
    endtask

    // Every external cycle kind, slow device on memory reads and on every write-type cycle, output included
    task automatic t_kinds();
        int          k;
        logic        rk, wk;
        logic [15:0] a;
        for (k = 0; k < 7; k++) begin
            rk = (k == 0 || k == 1 || k == 3);
            wk = (k == 2 || k == 4 || k == 6);
            a = 16'h4a00 + 16'(k * 17);
            @(posedge mclk_i);
            stall <= 1'b0;
            @(posedge mclk_i);
            stall <= (k == 1) || wk;
            hold_i <= (k == 1);
            run(3'(k), a, 2'h0, 1'b0);
            `CHK("status", stab[k], st)
            `CHK("address", a, ad)
            `CHK("strobe cycles", rk ? 2 + wt : 0, dlen)
            `CHK("write cycles", wk ? 1 + wt : 0, wlen)
            `CHK("waited", (k == 1) || wk, wt != 0)
            `CHK("cycle length", 2 + wt, len)
            `CHK("fetch flag", 1'(k == 0), fd)
            `CHK("hold seen", 1'(k == 1), hold_sampled_o)
            if (wk) begin
                `CHK("written", ~a[7:0], wr_byte)
                `CHK("output held", 1'b0, wbad)
            end else begin
                `CHK("read byte", a[7:0] ^ 8'h5a, rd)
            end
            if (k == 5) `CHK("released", 1'b1, oe2)
        end
    endtask

    // Internal states lengthen the cycle without bus activity
    task automatic t_internal();
        int n;
        for (n = 0; n < 3; n++) begin
            run(CBS_KIND_MEM_READ, 16'h0300, 2'(n), 1'b0);
            `CHK("cycle length", 2 + n + wt, len)
            `CHK("strobe cycles", 2 + wt, dlen)
        end
    endtask

    // Each restart target, then a disabled request
    task automatic t_irq();
        int   f;
        logic en;
        for (f = 0; f < 9; f++) begin
            en = (f < 8);
            @(posedge mclk_i);
            {irq_enable_set_i, irq_enable_clr_i} <= {en, !en};
            jam <= 8'hc7 | 8'(f << 3);
            irq_req <= 1'b1;
            @(posedge mclk_i);
            {irq_enable_set_i, irq_enable_clr_i} <= 2'b00;
            run(CBS_KIND_MEM_READ, 16'h0200, 2'h0, 1'b1);
            `CHK("enable flag", en, irq_enable_out_o)
            @(posedge mclk_i);
            irq_req <= 1'b0;
            run(CBS_KIND_FETCH, 16'h1230 + 16'(f), 2'h0, 1'b0);
            `CHK("ack cycle", en, ack)
            if (en) begin
                `CHK("ack status", 8'h21, st & 8'h21)
                `CHK("ack address", 16'h1230 + 16'(f), ad)
                `CHK("restart seen", 1'b1, rvs)
                `CHK("restart target", 16'(f * 8), rv)
                `CHK("enable cleared", 1'b0, irq_enable_out_o)
            end
            run(CBS_KIND_FETCH, 16'h1240, 2'h0, 1'b0);
            `CHK("single ack", 1'b0, ack)
        end
    endtask

    // Clock at 8 ns
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end

    // Cut a hang short
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            test_done();
        end
    end

    // Reset, then the scenarios
    initial begin
        repeat (16) @(posedge mclk_i);
        nrst_i <= 1'b1;
        t_kinds();
        t_internal();
        t_irq();
        test_done();
    end
endmodule

`default_nettype wire
